// [common/ubd_pkg.sv]
// Constants and types for the utility bus peripheral decode block
`default_nettype none
package ubd_pkg;
  // Encoded select codes, first decoder
  localparam logic [2:0] CODE_CLK_STROBE = 3'h0;
  localparam logic [2:0] CODE_CLK_SEL = 3'h1;
  localparam logic [2:0] CODE_KEYS = 3'h2;
  localparam logic [2:0] CODE_BOOT = 3'h3;
  localparam logic [2:0] CODE_DISKETTE = 3'h4;
  localparam logic [2:0] CODE_DISK_CMD = 3'h5;
  localparam logic [2:0] CODE_DISK_CTL = 3'h6;
  // Encoded select codes, second decoder
  localparam logic [2:0] CODE_CFG_PAGE = 3'h1;
  localparam logic [2:0] CODE_CFG_RAM = 3'h2;
  localparam logic [2:0] CODE_SERIAL_A = 3'h3;
  localparam logic [2:0] CODE_SERIAL_B = 3'h4;
  localparam logic [2:0] CODE_PRINTER = 3'h5;
  localparam logic [2:0] CODE_IDLE = 3'h7;
  // I/O addresses and range bases
  localparam logic [15:0] IO_CLK_BASE = 16'h0070;
  localparam logic [15:0] IO_KEYS_BASE = 16'h0060;
  localparam logic [15:0] IO_DISKETTE_PRI = 16'h03F0;
  localparam logic [15:0] IO_DISKETTE_SEC = 16'h0370;
  localparam logic [15:0] IO_DISK_CMD_PRI = 16'h01F0;
  localparam logic [15:0] IO_DISK_CMD_SEC = 16'h0170;
  localparam logic [15:0] IO_DISK_CTL_PRI = 16'h03F6;
  localparam logic [15:0] IO_DISK_CTL_SEC = 16'h0376;
  localparam logic [15:0] IO_MEDIA_PRI = 16'h03F7;
  localparam logic [15:0] IO_MEDIA_SEC = 16'h0377;
  localparam logic [15:0] IO_CFG_PAGE = 16'h0C00;
  localparam logic [15:0] IO_CFG_RAM_BASE = 16'h0800;
  localparam logic [15:0] IO_SERIAL_PRI = 16'h03F8;
  localparam logic [15:0] IO_SERIAL_ALT = 16'h02F8;
  localparam logic [15:0] IO_PRN_3BC = 16'h03BC;
  localparam logic [15:0] IO_PRN_378 = 16'h0378;
  localparam logic [15:0] IO_PRN_278 = 16'h0278;
  localparam logic [15:0] IO_ALT_CTRL = 16'h0092;
  localparam logic [15:0] IO_FPU_CLEAR = 16'h00F0;
  // Boot memory 64 KB segments, upper address half
  localparam logic [15:0] MEM_BOOT_F = 16'h000F;
  localparam logic [15:0] MEM_BOOT_F_TOP = 16'hFFFF;
  localparam logic [15:0] MEM_BOOT_F_LOW = 16'hFFEF;
  localparam logic [15:0] MEM_BOOT_E = 16'h000E;
  localparam logic [15:0] MEM_BOOT_E_TOP = 16'hFFFE;
  localparam logic [15:0] MEM_BOOT_E_LOW = 16'hFFEE;
  localparam logic [15:0] MEM_BOOT_EXT = 16'hFFFD;
  // Printer range selection
  localparam logic [1:0] PRN_SEL_3BC = 2'h0;
  localparam logic [1:0] PRN_SEL_378 = 2'h1;
  localparam logic [1:0] PRN_SEL_278 = 2'h2;
  // Alternate reset and gate control register
  localparam logic [7:0] ALT_CTRL_RST = 8'h00;
  localparam int ALT_RESET_BIT = 0;
  localparam int ALTERNATE_GATE_A20_BIT = 1;
  typedef enum logic [1:0] {FPU_IDLE, FPU_IRQ, FPU_IGNORE} ubd_fpu_t;
endpackage
`default_nettype wire

// [src/ubd_decode.sv]
// Utility bus peripheral decode, buffer control and coprocessor error logic
// Notes on behaviour
// [RULE1] Drive three-bit code plus decoder pick line
// [RULE2] First decoder: clock strobe, clock, keys
// [RULE3] First decoder: boot, diskette, disk ranges
// [RULE4] Second decoder: config, serial, printer, idle
// [RULE5] Top boot segment and aliases always decoded
// [RULE6] Lower boot segment decoded only when enabled
// [RULE7] Extra boot region below 4 GB when enabled
// [RULE8] One diskette/disk range decoded at a time
// [RULE9] One shared primary/secondary choice for both
// [RULE10] Each serial select picks one of two ranges
// [RULE11] Printer select decodes one programmed range
// [RULE12] Drive transceiver enable and direction outputs
// [RULE13] Alternate_reset_gate_control drives alternate reset and A20
// [RULE14] Media port read drives inverted media change
// [RULE15] Data line 7 and buffer per decode enables
// [RULE16] Software avoids disk on with diskette off
// [RULE17] Mode bit selects coprocessor error pin use
// [RULE18] Coprocessor error raises COPROC_IRQ_LINE and interrupt out
// [RULE19] Write F0h drops COPROC_IRQ_LINE, sets ignore error
// [RULE20] Ignore error held until error input clears
// [RULE21] Mode off: pin is ordinary COPROC_IRQ_LINE input
// [RULE22] No match holds idle code on decoder two
`default_nettype none
module ubd_decode (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [31:0] isa_addr,
  input wire logic io_read,
  input wire logic io_write,
  input wire logic mem_read,
  input wire logic mem_write,
  input wire logic [7:0] isa_wdata,
  input wire logic media_change_in,
  input wire logic coproc_error_in_n,
  input wire logic coproc_mode,
  input wire logic low_boot_en,
  input wire logic boot_ext_en,
  input wire logic drive_secondary,
  input wire logic diskette_dec_en,
  input wire logic disk_dec_en,
  input wire logic serial_a_en,
  input wire logic serial_a_alt,
  input wire logic serial_b_en,
  input wire logic serial_b_alt,
  input wire logic printer_en,
  input wire logic [1:0] printer_range,
  output logic [2:0] encoded_select_code,
  output logic decoder_pick_n,
  output logic peripheral_buffer_oe_n,
  output logic peripheral_buffer_dir,
  output logic sd7_out,
  output logic sd7_oe,
  output logic [7:0] rd_data,
  output logic rd_data_oe,
  output logic fallback_cpu_reset,
  output logic alternate_gate_a20,
  output logic coproc_irq_line,
  output logic cpu_int_out,
  output logic ignore_numeric_err_n
);

  logic [15:0] io_addr;
  logic io_cyc;
  logic mem_cyc;
  logic [15:0] seg;
  logic [15:0] diskette_base;
  logic [15:0] disk_cmd_base;
  logic [15:0] disk_ctl_base;
  logic [15:0] media_port;
  logic [15:0] serial_a_base;
  logic [15:0] serial_b_base;
  logic printer_hit;
  logic boot_hit;
  logic media_read;
  logic hit;
  logic [2:0] next_code;
  logic next_pick_n;
  logic next_buf_en;
  logic next_sd7_oe;
  logic [7:0] alt_ctrl;
  logic fpu_clear_wr;
  logic err_active;
  ubd_pkg::ubd_fpu_t fpu_state;
  ubd_pkg::ubd_fpu_t next_fpu_state;

  assign io_addr = isa_addr[15:0];
  assign seg = isa_addr[31:16];
  assign io_cyc = io_read | io_write;
  assign mem_cyc = mem_read | mem_write;
  assign err_active = ~coproc_error_in_n;
  assign fpu_clear_wr = io_write && (io_addr == ubd_pkg::IO_FPU_CLEAR);

  // One bit chooses both drive ranges so they never split
  always_comb begin
    diskette_base = ubd_pkg::IO_DISKETTE_PRI; // RULE9
    disk_cmd_base = ubd_pkg::IO_DISK_CMD_PRI;
    disk_ctl_base = ubd_pkg::IO_DISK_CTL_PRI;
    media_port = ubd_pkg::IO_MEDIA_PRI;
    if (drive_secondary) begin // RULE8
      diskette_base = ubd_pkg::IO_DISKETTE_SEC;
      disk_cmd_base = ubd_pkg::IO_DISK_CMD_SEC;
      disk_ctl_base = ubd_pkg::IO_DISK_CTL_SEC;
      media_port = ubd_pkg::IO_MEDIA_SEC;
    end
  end

  assign serial_a_base = serial_a_alt ? ubd_pkg::IO_SERIAL_ALT :
                         ubd_pkg::IO_SERIAL_PRI; // RULE10
  assign serial_b_base = serial_b_alt ? ubd_pkg::IO_SERIAL_ALT :
                         ubd_pkg::IO_SERIAL_PRI; // RULE10

  always_comb begin
    case (printer_range) // RULE11
      ubd_pkg::PRN_SEL_3BC:
        printer_hit = io_addr[15:2] == ubd_pkg::IO_PRN_3BC[15:2];
      ubd_pkg::PRN_SEL_378:
        printer_hit = io_addr[15:3] == ubd_pkg::IO_PRN_378[15:3];
      ubd_pkg::PRN_SEL_278:
        printer_hit = io_addr[15:3] == ubd_pkg::IO_PRN_278[15:3];
      default: printer_hit = 1'b0;
    endcase
  end

  always_comb begin
    boot_hit = (seg == ubd_pkg::MEM_BOOT_F) ||
               (seg == ubd_pkg::MEM_BOOT_F_TOP) ||
               (seg == ubd_pkg::MEM_BOOT_F_LOW); // RULE5
    if (low_boot_en) begin // RULE6
      boot_hit = boot_hit || (seg == ubd_pkg::MEM_BOOT_E) ||
                 (seg == ubd_pkg::MEM_BOOT_E_TOP) ||
                 (seg == ubd_pkg::MEM_BOOT_E_LOW);
    end
    if (boot_ext_en) begin // RULE7
      boot_hit = boot_hit || (seg == ubd_pkg::MEM_BOOT_EXT);
    end
  end

  assign media_read = io_read && (io_addr == media_port);

  // Disk control wins over diskette where the two ranges overlap
  always_comb begin
    hit = 1'b1;
    next_pick_n = 1'b0; // RULE1
    next_code = ubd_pkg::CODE_IDLE;
    if (mem_cyc && boot_hit) begin
      next_code = ubd_pkg::CODE_BOOT; // RULE3
    end else if (!io_cyc) begin
      hit = 1'b0;
    end else if (io_write && !io_addr[0] &&
                 io_addr[15:3] == ubd_pkg::IO_CLK_BASE[15:3]) begin
      next_code = ubd_pkg::CODE_CLK_STROBE; // RULE2
    end else if (io_addr[0] &&
                 io_addr[15:3] == ubd_pkg::IO_CLK_BASE[15:3]) begin
      next_code = ubd_pkg::CODE_CLK_SEL; // RULE2
    end else if (!io_addr[0] &&
                 io_addr[15:3] == ubd_pkg::IO_KEYS_BASE[15:3]) begin
      next_code = ubd_pkg::CODE_KEYS; // RULE2
    end else if (disk_dec_en && io_addr[15:1] == disk_ctl_base[15:1]) begin
      next_code = ubd_pkg::CODE_DISK_CTL; // RULE3
    end else if (diskette_dec_en &&
                 io_addr[15:3] == diskette_base[15:3]) begin
      next_code = ubd_pkg::CODE_DISKETTE; // RULE3
    end else if (disk_dec_en && io_addr[15:3] == disk_cmd_base[15:3]) begin
      next_code = ubd_pkg::CODE_DISK_CMD; // RULE3
    end else begin
      next_pick_n = 1'b1; // RULE4
      if (io_addr == ubd_pkg::IO_CFG_PAGE) begin
        next_code = ubd_pkg::CODE_CFG_PAGE;
      end else if (io_addr[15:8] == ubd_pkg::IO_CFG_RAM_BASE[15:8]) begin
        next_code = ubd_pkg::CODE_CFG_RAM;
      end else if (serial_a_en &&
                   io_addr[15:3] == serial_a_base[15:3]) begin
        next_code = ubd_pkg::CODE_SERIAL_A;
      end else if (serial_b_en &&
                   io_addr[15:3] == serial_b_base[15:3]) begin
        next_code = ubd_pkg::CODE_SERIAL_B;
      end else if (printer_en && printer_hit) begin
        next_code = ubd_pkg::CODE_PRINTER;
      end else begin
        hit = 1'b0;
      end
    end
    if (!hit) begin
      next_pick_n = 1'b1; // RULE22
      next_code = ubd_pkg::CODE_IDLE;
    end
  end

  // Buffer stays off while the block itself drives data line 7
  always_comb begin
    next_buf_en = hit;
    next_sd7_oe = 1'b0;
    if (media_read && diskette_dec_en && !disk_dec_en) begin // RULE15
      next_buf_en = 1'b0;
      next_sd7_oe = 1'b1; // RULE14
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      encoded_select_code <= ubd_pkg::CODE_IDLE;
      decoder_pick_n <= 1'b1;
    end else begin
      encoded_select_code <= next_code; // RULE1
      decoder_pick_n <= next_pick_n;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      peripheral_buffer_oe_n <= 1'b1;
      peripheral_buffer_dir <= 1'b0;
      sd7_out <= 1'b0;
      sd7_oe <= 1'b0;
    end else begin
      peripheral_buffer_oe_n <= ~next_buf_en; // RULE12
      peripheral_buffer_dir <= next_buf_en && (io_read || mem_read);
      sd7_out <= ~media_change_in; // RULE14
      sd7_oe <= next_sd7_oe;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      alt_ctrl <= ubd_pkg::ALT_CTRL_RST;
    end else if (io_write && io_addr == ubd_pkg::IO_ALT_CTRL) begin
      alt_ctrl <= isa_wdata; // RULE13
    end
  end

  assign fallback_cpu_reset = alt_ctrl[ubd_pkg::ALT_RESET_BIT];
  assign alternate_gate_a20 = alt_ctrl[ubd_pkg::ALTERNATE_GATE_A20_BIT];

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rd_data <= 8'h00;
      rd_data_oe <= 1'b0;
    end else begin
      rd_data_oe <= io_read && io_addr == ubd_pkg::IO_ALT_CTRL;
      rd_data <= alt_ctrl;
    end
  end

  // With mode on, a live error always wins over leaving the ignore state
  always_comb begin
    next_fpu_state = fpu_state;
    case (fpu_state)
      ubd_pkg::FPU_IDLE: begin
        if (coproc_mode && err_active) begin // RULE17
          next_fpu_state = ubd_pkg::FPU_IRQ;
        end
      end
      ubd_pkg::FPU_IRQ: begin
        if (!coproc_mode || !err_active) begin
          next_fpu_state = ubd_pkg::FPU_IDLE;
        end else if (fpu_clear_wr) begin // RULE19
          next_fpu_state = ubd_pkg::FPU_IGNORE;
        end
      end
      ubd_pkg::FPU_IGNORE: begin
        if (!coproc_mode || !err_active) begin // RULE20
          next_fpu_state = ubd_pkg::FPU_IDLE;
        end
      end
      default: next_fpu_state = ubd_pkg::FPU_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      fpu_state <= ubd_pkg::FPU_IDLE;
      coproc_irq_line <= 1'b0;
      cpu_int_out <= 1'b0;
      ignore_numeric_err_n <= 1'b1;
    end else begin
      fpu_state <= next_fpu_state;
      // Pin level is passed through as a plain request when mode is off
      coproc_irq_line <= coproc_mode ?
                         (next_fpu_state == ubd_pkg::FPU_IRQ) :
                         coproc_error_in_n; // RULE21
      cpu_int_out <= coproc_mode &&
                     next_fpu_state == ubd_pkg::FPU_IRQ; // RULE18
      ignore_numeric_err_n <= next_fpu_state != ubd_pkg::FPU_IGNORE; // RULE19
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  AST_IDLE_CODE: assert property ( // RULE22
    !io_read && !io_write && !mem_read && !mem_write |=>
    encoded_select_code == ubd_pkg::CODE_IDLE && decoder_pick_n)
    else $error("idle code not held without a cycle");

  AST_CLK_STROBE: assert property ( // RULE2
    io_write && !io_read && !mem_cyc && io_addr == 16'h0074 |=>
    encoded_select_code == ubd_pkg::CODE_CLK_STROBE && !decoder_pick_n)
    else $error("clock strobe code missing");

  AST_BOOT_TOP: assert property ( // RULE5
    mem_cyc && seg == ubd_pkg::MEM_BOOT_F_LOW |=>
    encoded_select_code == ubd_pkg::CODE_BOOT && !decoder_pick_n)
    else $error("top boot alias not decoded");

  AST_LOW_BOOT_OFF: assert property ( // RULE6
    mem_cyc && !io_cyc && !low_boot_en && seg == ubd_pkg::MEM_BOOT_E |=>
    encoded_select_code == ubd_pkg::CODE_IDLE && decoder_pick_n)
    else $error("lower boot decoded while disabled");

  AST_BOOT_EXT: assert property ( // RULE7
    mem_cyc && boot_ext_en && seg == ubd_pkg::MEM_BOOT_EXT |=>
    encoded_select_code == ubd_pkg::CODE_BOOT)
    else $error("extended boot region not decoded");

  AST_SHARED_RANGE: assert property ( // RULE8
    io_cyc && !mem_cyc && drive_secondary && io_addr == 16'h03F2 |=>
    encoded_select_code == ubd_pkg::CODE_IDLE && decoder_pick_n)
    else $error("primary range decoded under secondary");

  AST_MEDIA_DRIVE: assert property ( // RULE14
    media_read && !mem_cyc && diskette_dec_en && !disk_dec_en |=>
    sd7_oe && sd7_out == !$past(media_change_in) && peripheral_buffer_oe_n)
    else $error("media change not driven on data line 7");

  AST_MEDIA_BOTH: assert property ( // RULE15
    media_read && !mem_cyc && diskette_dec_en && disk_dec_en |=>
    !sd7_oe && !peripheral_buffer_oe_n ##1 !sd7_oe || peripheral_buffer_oe_n)
    else $error("buffer or line 7 wrong with both decodes on");

  AST_IGN_CAUSE: assert property ( // RULE19
    $fell(ignore_numeric_err_n) |->
    $past(fpu_clear_wr && err_active && coproc_mode))
    else $error("ignore error raised without cause");

  AST_IGN_RELEASE: assert property ( // RULE20
    !ignore_numeric_err_n && coproc_error_in_n |=> ignore_numeric_err_n)
    else $error("ignore error held after error cleared");

  AST_IRQ_RAISE: assert property ( // RULE18
    coproc_mode && err_active && fpu_state == ubd_pkg::FPU_IDLE |=>
    coproc_irq_line && cpu_int_out)
    else $error("coprocessor error did not raise interrupt");

  AST_EXT_IRQ: assert property ( // RULE21
    !coproc_mode |=> coproc_irq_line == $past(coproc_error_in_n)
    && !cpu_int_out)
    else $error("external interrupt not passed through");

  AST_ALT_CTRL: assert property ( // RULE13
    io_write && io_addr == ubd_pkg::IO_ALT_CTRL |=>
    fallback_cpu_reset == $past(isa_wdata[0]) &&
    alternate_gate_a20 == $past(isa_wdata[1]))
    else $error("alternate reset or gate not updated");

  COV_BOOT: cover property (mem_cyc && boot_hit ##1 !decoder_pick_n);
  COV_MEDIA: cover property (next_sd7_oe ##1 sd7_oe);
  COV_IGNORE: cover property (
    fpu_state == ubd_pkg::FPU_IRQ ##1 fpu_state == ubd_pkg::FPU_IGNORE
    ##[1:20] fpu_state == ubd_pkg::FPU_IDLE);
  COV_PRINTER: cover property (
    encoded_select_code == ubd_pkg::CODE_PRINTER && decoder_pick_n);

endmodule
`default_nettype wire

// [tb/ubd_periph_model.sv]
// External decoder pair and data line 7 model for the decode bench
`default_nettype none
module ubd_periph_model (
  input wire logic mclk,
  input wire logic [2:0] encoded_select_code,
  input wire logic decoder_pick_n,
  input wire logic sd7_out,
  input wire logic sd7_oe,
  output logic [15:0] sel_n,
  output logic sd7_wire
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] idx;
  logic sd7_last = 1'b0;
  assign idx = {decoder_pick_n, encoded_select_code};
  // Idle code on decoder two selects no device
  assign sel_n = (idx == 4'hF) ? 16'hFFFF :
                 ~(16'h0001 << idx);
  // No pull on the line: undriven it toggles so stale data never passes
  always @(posedge mclk) sd7_last <= sd7_wire;
  assign sd7_wire = sd7_oe ? sd7_out : ~sd7_last;
endmodule
`default_nettype wire

// [tb/tb_ubd_decode.sv]
// Self-checking bench for the utility bus peripheral decode block
`default_nettype none
module tb_ubd_decode;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [2:0] K_NO = 3'h0, K_IOR = 3'h1, K_IOW = 3'h2;
  localparam logic [2:0] K_MR = 3'h3, K_MW = 3'h4;
  localparam logic [3:0] D1_STB = {1'b0, ubd_pkg::CODE_CLK_STROBE};
  localparam logic [3:0] D1_CLK = {1'b0, ubd_pkg::CODE_CLK_SEL};
  localparam logic [3:0] D1_KEY = {1'b0, ubd_pkg::CODE_KEYS};
  localparam logic [3:0] D1_BOOT = {1'b0, ubd_pkg::CODE_BOOT};
  localparam logic [3:0] D1_FDD = {1'b0, ubd_pkg::CODE_DISKETTE};
  localparam logic [3:0] D1_CMD = {1'b0, ubd_pkg::CODE_DISK_CMD};
  localparam logic [3:0] D1_CTL = {1'b0, ubd_pkg::CODE_DISK_CTL};
  localparam logic [3:0] D2_PAGE = {1'b1, ubd_pkg::CODE_CFG_PAGE};
  localparam logic [3:0] D2_RAM = {1'b1, ubd_pkg::CODE_CFG_RAM};
  localparam logic [3:0] D2_SA = {1'b1, ubd_pkg::CODE_SERIAL_A};
  localparam logic [3:0] D2_SB = {1'b1, ubd_pkg::CODE_SERIAL_B};
  localparam logic [3:0] D2_PRN = {1'b1, ubd_pkg::CODE_PRINTER};
  localparam logic [3:0] IDLE = {1'b1, ubd_pkg::CODE_IDLE};
  logic mclk = 1'b0, resetn = 1'b0;
  logic [31:0] isa_addr = 32'h0;
  logic [7:0] isa_wdata = 8'h00;
  logic io_read = 1'b0, io_write = 1'b0, mem_read = 1'b0, mem_write = 1'b0;
  logic media_change_in = 1'b0, coproc_error_in_n = 1'b1;
  logic coproc_mode = 1'b0, low_boot_en = 1'b0, boot_ext_en = 1'b0;
  logic drive_secondary = 1'b0, diskette_dec_en = 1'b0, disk_dec_en = 1'b0;
  logic serial_a_en = 1'b0, serial_a_alt = 1'b0;
  logic serial_b_en = 1'b0, serial_b_alt = 1'b0;
  logic printer_en = 1'b0;
  logic [1:0] printer_range = 2'h3;
  logic [2:0] encoded_select_code;
  logic [7:0] rd_data;
  logic decoder_pick_n, peripheral_buffer_oe_n, peripheral_buffer_dir;
  logic sd7_out, sd7_oe, rd_data_oe, fallback_cpu_reset, alternate_gate_a20;
  logic coproc_irq_line, cpu_int_out, ignore_numeric_err_n, sd7_wire;
  logic [15:0] sel_n;
  int bad_count = 0;
  int checked = 0;
  always #25 mclk = ~mclk;
  ubd_decode i_ubd_decode (
    .mclk, .resetn, .isa_addr, .io_read, .io_write, .mem_read, .mem_write,
    .isa_wdata, .media_change_in, .coproc_error_in_n, .coproc_mode,
    .low_boot_en, .boot_ext_en, .drive_secondary, .diskette_dec_en,
    .disk_dec_en, .serial_a_en, .serial_a_alt, .serial_b_en, .serial_b_alt,
    .printer_en, .printer_range, .encoded_select_code, .decoder_pick_n,
    .peripheral_buffer_oe_n, .peripheral_buffer_dir, .sd7_out, .sd7_oe,
    .rd_data, .rd_data_oe, .fallback_cpu_reset, .alternate_gate_a20,
    .coproc_irq_line, .cpu_int_out, .ignore_numeric_err_n
  );
  ubd_periph_model i_ubd_periph_model (
    .mclk, .encoded_select_code, .decoder_pick_n, .sd7_out, .sd7_oe,
    .sel_n, .sd7_wire
  );
  task automatic finish_test();
    if (bad_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    checked++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask
  // Applied at a falling edge, seen after the next falling edge
  task automatic cyc(input logic [2:0] k, input logic [31:0] a,
      input logic [7:0] d);
    io_read = (k == K_IOR);
    io_write = (k == K_IOW);
    mem_read = (k == K_MR);
    mem_write = (k == K_MW);
    isa_addr = a;
    isa_wdata = d;
    @(negedge mclk);
  endtask
  task automatic sel(input logic [2:0] k, input logic [31:0] a,
      input logic [3:0] idx, input string m);
    logic [15:0] e;
    e = (idx == 4'hF) ? 16'hFFFF : ~(16'h0001 << idx);
    cyc(k, a, 8'h00);
    chk({decoder_pick_n, encoded_select_code} === idx && sel_n === e, m);
  endtask
  task automatic t_first();
    for (int i = 0; i < 8; i += 2) begin
      sel(K_IOW, 32'h70 + i, D1_STB, "clock strobe");
      sel(K_IOR, 32'h70 + i, IDLE, "strobe read");
      sel(K_IOR, 32'h71 + i, D1_CLK, "clock read");
      sel(K_IOW, 32'h71 + i, D1_CLK, "clock write");
      sel(K_IOR, 32'h60 + i, D1_KEY, "keys read");
      sel(K_IOW, 32'h60 + i, D1_KEY, "keys write");
      sel(K_IOW, 32'h61 + i, IDLE, "keys odd");
    end
    sel(K_IOR, 32'h68, IDLE, "keys end");
    cyc(K_IOR, 32'h64, 8'h00);
    chk(peripheral_buffer_oe_n === 1'b0 &&
        peripheral_buffer_dir === 1'b1, "buf rd");
    cyc(K_IOW, 32'h64, 8'h00);
    chk(peripheral_buffer_oe_n === 1'b0 &&
        peripheral_buffer_dir === 1'b0, "buf wr");
    cyc(K_NO, 32'h64, 8'h00);
    chk(peripheral_buffer_oe_n === 1'b1 &&
        sel_n === 16'hFFFF, "no cycle");
  endtask
  task automatic t_boot();
    sel(K_MR, 32'h000F0000, D1_BOOT, "boot F");
    sel(K_MW, 32'hFFFFFFFF, D1_BOOT, "boot F top");
    sel(K_MR, 32'hFFEF8000, D1_BOOT, "boot F alias");
    sel(K_MR, 32'h000E0000, IDLE, "E off");
    sel(K_MR, 32'hFFFE1234, IDLE, "E top off");
    sel(K_MR, 32'hFFFD0000, IDLE, "ext off");
    low_boot_en = 1'b1;
    boot_ext_en = 1'b1;
    sel(K_MR, 32'h000EFFFF, D1_BOOT, "E on");
    sel(K_MW, 32'hFFEE0000, D1_BOOT, "E alias on");
    sel(K_MR, 32'hFFFDFFFF, D1_BOOT, "ext on");
    sel(K_MR, 32'hFFFC0000, IDLE, "below ext");
    sel(K_MR, 32'h00100000, IDLE, "above boot");
  endtask
  task automatic t_drives();
    diskette_dec_en = 1'b1;
    disk_dec_en = 1'b1;
    for (int s = 0; s < 2; s++) begin
      drive_secondary = s[0];
      sel(K_IOR, s ? 32'h370 : 32'h3F0, D1_FDD, "diskette");
      sel(K_IOW, s ? 32'h3F2 : 32'h370, IDLE, "diskette other");
      sel(K_IOW, s ? 32'h177 : 32'h1F7, D1_CMD, "cmd");
      sel(K_IOR, s ? 32'h1F0 : 32'h170, IDLE, "cmd other");
      sel(K_IOR, s ? 32'h376 : 32'h3F6, D1_CTL, "ctl");
      sel(K_IOR, s ? 32'h3F6 : 32'h376, IDLE, "ctl other");
    end
    disk_dec_en = 1'b0;
    drive_secondary = 1'b0;
    sel(K_IOR, 32'h3F6, D1_FDD, "ctl off");
  endtask
  task automatic t_media();
    for (int m = 0; m < 2; m++) begin
      media_change_in = m[0];
      drive_secondary = m[0];
      diskette_dec_en = 1'b1;
      disk_dec_en = 1'b0;
      cyc(K_IOR, m ? 32'h377 : 32'h3F7, 8'h00);
      chk(sd7_oe === 1'b1 && sd7_wire === ~m[0] &&
          peripheral_buffer_oe_n === 1'b1, "media drive");
      disk_dec_en = 1'b1;
      cyc(K_IOR, m ? 32'h377 : 32'h3F7, 8'h00);
      chk(sd7_oe === 1'b0 &&
          peripheral_buffer_oe_n === 1'b0, "both on");
      // Disk on with diskette off is never programmed
      diskette_dec_en = 1'b0;
      disk_dec_en = 1'b0;
      cyc(K_IOR, m ? 32'h377 : 32'h3F7, 8'h00);
      chk(sd7_oe === 1'b0 &&
          peripheral_buffer_oe_n === 1'b1, "both off");
    end
    diskette_dec_en = 1'b1;
    cyc(K_IOW, 32'h377, 8'h00);
    chk(sd7_oe === 1'b0, "media write");
    diskette_dec_en = 1'b0;
  endtask
  task automatic t_dec2();
    sel(K_IOW, 32'h0C00, D2_PAGE, "page");
    sel(K_IOR, 32'h0C01, IDLE, "page next");
    sel(K_IOR, 32'h0800, D2_RAM, "cfg low");
    sel(K_IOW, 32'h08FF, D2_RAM, "cfg high");
    sel(K_IOR, 32'h0900, IDLE, "cfg end");
    serial_a_en = 1'b1;
    serial_b_en = 1'b1;
    serial_b_alt = 1'b1;
    sel(K_IOR, 32'h3F8, D2_SA, "ser a");
    sel(K_IOW, 32'h2FF, D2_SB, "ser b");
    serial_a_alt = 1'b1;
    serial_b_alt = 1'b0;
    sel(K_IOW, 32'h2F8, D2_SA, "ser a alt");
    sel(K_IOR, 32'h3FF, D2_SB, "ser b pri");
    serial_a_en = 1'b0;
    serial_b_en = 1'b0;
    sel(K_IOR, 32'h3FF, IDLE, "ser off");
    printer_en = 1'b1;
    for (int p = 0; p < 4; p++) begin
      printer_range = p[1:0];
      sel(K_IOR, 32'h3BC, p == ubd_pkg::PRN_SEL_3BC ? D2_PRN : IDLE,
          "p3BC");
      sel(K_IOW, 32'h37F, p == ubd_pkg::PRN_SEL_378 ? D2_PRN : IDLE,
          "p378");
      sel(K_IOR, 32'h278, p == ubd_pkg::PRN_SEL_278 ? D2_PRN : IDLE,
          "p278");
    end
  endtask
  task automatic t_port92();
    cyc(K_IOW, 32'h92, 8'h02);
    chk(alternate_gate_a20 === 1'b1 &&
        fallback_cpu_reset === 1'b0, "a20");
    chk(sel_n === 16'hFFFF &&
        peripheral_buffer_oe_n === 1'b1, "92 quiet");
    cyc(K_IOW, 32'h92, 8'hA5);
    chk(fallback_cpu_reset === 1'b1 &&
        alternate_gate_a20 === 1'b0, "rst");
    cyc(K_IOR, 32'h92, 8'h00);
    chk(rd_data_oe === 1'b1 && rd_data === 8'hA5, "readback");
    cyc(K_IOW, 32'h93, 8'h00);
    chk(rd_data_oe === 1'b0 &&
        fallback_cpu_reset === 1'b1, "port 93");
    resetn = 1'b0;
    @(negedge mclk);
    chk(fallback_cpu_reset === 1'b0 &&
        sel_n === 16'hFFFF, "in reset");
    resetn = 1'b1;
    cyc(K_IOR, 32'h92, 8'h00);
    chk(rd_data === ubd_pkg::ALT_CTRL_RST &&
        rd_data_oe === 1'b1, "reset val");
  endtask
  task automatic t_coproc();
    coproc_mode = 1'b1;
    cyc(K_IOW, 32'hF0, 8'h00);
    chk(ignore_numeric_err_n === 1'b1 &&
        coproc_irq_line === 1'b0, "F0 idle");
    coproc_error_in_n = 1'b0;
    cyc(K_NO, 32'h0, 8'h00);
    chk(coproc_irq_line === 1'b1 &&
        cpu_int_out === 1'b1, "err");
    cyc(K_IOW, 32'hF0, 8'h00);
    chk(coproc_irq_line === 1'b0 && cpu_int_out === 1'b0 &&
        ignore_numeric_err_n === 1'b0, "F0");
    cyc(K_NO, 32'h0, 8'h00);
    cyc(K_NO, 32'h0, 8'h00);
    chk(ignore_numeric_err_n === 1'b0 &&
        cpu_int_out === 1'b0, "held");
    coproc_error_in_n = 1'b1;
    cyc(K_NO, 32'h0, 8'h00);
    chk(ignore_numeric_err_n === 1'b1 &&
        coproc_irq_line === 1'b0, "gone");
    coproc_mode = 1'b0;
    coproc_error_in_n = 1'b0;
    cyc(K_NO, 32'h0, 8'h00);
    chk(coproc_irq_line === 1'b0 &&
        cpu_int_out === 1'b0, "plain low");
    coproc_error_in_n = 1'b1;
    cyc(K_NO, 32'h0, 8'h00);
    chk(coproc_irq_line === 1'b1 &&
        cpu_int_out === 1'b0, "plain high");
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    $display("CHECK FAILED at %0t: run timed out", $time);
    finish_test();
  end
  initial begin
    repeat (12) @(negedge mclk);
    resetn = 1'b1;
    t_first();
    t_boot();
    t_drives();
    t_media();
    t_dec2();
    t_port92();
    t_coproc();
    finish_test();
  end
endmodule
`default_nettype wire
